/* File: usc_pkg.sv */
// constants, field layout and state codes of the serial status and control block
// assumes a 16-bit status/control word mapped on a 32-bit classic wishbone slave
// Behaviour
// [RQ1] tx irq per transfer, or when buffer empties
// [RQ2] select 01 irq after last bit; 11 reserved
// [RQ3] polarity bit flips tx idle level, both codings
// [RQ4] break: start, twelve zeros, stop; self clears
// [RQ5] tx enable clear aborts, flushes, releases pin
// [RQ6] read-only tx buffer full flag
// [RQ7] shifter empty flag, resets one, idle only
// [RQ8] rx select 11 irq when buffer reaches four
// [RQ9] rx select 10 irq when buffer reaches three
// [RQ10] rx select 0x irq on every character
// [RQ11] address detect keeps ninth-bit-set characters only
// [RQ12] rx idle flag, resets one, low receiving
// [RQ13] parity error flag of head character
// [RQ14] framing error flag of head character
// [RQ15] overrun set on overflow; clearing flushes receiver
// [RQ16] data available flag while buffer holds data
// [RQ17] reading rx data advances queue and flags
// [RQ18] format 11 is nine bits, no parity
// [RQ19] software break: enable, request, dummy write
// [RQ20] read-only bits ignore writes; overrun clear only
// [RQ21] reset: controls zero, idle flags one
package usc_pkg;
	localparam logic [3:0] USC_ADR_STATUS = 4'h0;
	localparam logic [3:0] USC_ADR_TXDATA = 4'h4;
	localparam logic [3:0] USC_ADR_RXDATA = 4'h8;
	localparam logic [3:0] USC_ADR_CONFIG = 4'hc;
	localparam int USC_B_TXISEL1 = 15;
	localparam int USC_B_TX_POLARITY_INVERT = 14;
	localparam int USC_B_TXISEL0 = 13;
	localparam int USC_B_TXBRK = 11;
	localparam int USC_B_TXEN = 10;
	localparam int USC_B_TXBF = 9;
	localparam int USC_B_TX_SHIFTER_EMPTY = 8;
	localparam int USC_B_RXISEL1 = 7;
	localparam int USC_B_RXISEL0 = 6;
	localparam int USC_B_ADDRESS_DETECT_ENABLE = 5;
	localparam int USC_B_RX_IDLE_FLAG = 4;
	localparam int USC_B_OVERRUN_ERROR_FLAG = 1;
	localparam int USC_B_RX_DATA_AVAILABLE = 0;
	localparam int USC_B_FMT1 = 1;
	localparam int USC_B_FMT0 = 0;
	localparam int USC_B_INFRARED_CODING_ENABLE = 2;
	localparam int USC_E_FRAMING_ERROR_FLAG = 10;
	localparam int USC_E_PARITY_ERROR_FLAG = 9;
	localparam int USC_E_ADDR = 8;
	localparam int USC_ENTRY_W = 11;
	localparam int USC_DATA_W = 9;
	localparam logic [1:0] USC_FMT_EVEN = 2'h1;
	localparam logic [1:0] USC_FMT_ODD = 2'h2;
	localparam logic [1:0] USC_FMT_NINE = 2'h3;
	localparam logic [1:0] USC_TXI_XFER = 2'h0;
	localparam logic [1:0] USC_TXI_DONE = 2'h1;
	localparam logic [1:0] USC_TXI_EMPTY = 2'h2;
	localparam logic [1:0] USC_RXI_FULL = 2'h3;
	localparam logic [1:0] USC_RXI_3Q = 2'h2;
	localparam int USC_QUEUE_DEPTH = 4;
	localparam int USC_RX_FULL_LEVEL = 4;
	localparam int USC_RX_3Q_LEVEL = 3;
	localparam logic [3:0] USC_LAST_BREAK = 4'hb;
	localparam logic [3:0] USC_LAST_NINE = 4'h8;
	localparam logic [3:0] USC_LAST_EIGHT = 4'h7;
	localparam int USC_BIT_CYCLES = 16;
	localparam int USC_IR_FRACTION = 4;
	localparam int USC_CNT_W = 16;
	typedef enum logic [2:0] {
		USC_TX_IDLE = 3'h0,
		USC_TX_START = 3'h1,
		USC_TX_DATA = 3'h2,
		USC_TX_PAR = 3'h3,
		USC_TX_STOP = 3'h4
	} usc_tx_state_t;
	typedef enum logic [2:0] {
		USC_RX_IDLE = 3'h0,
		USC_RX_START = 3'h1,
		USC_RX_DATA = 3'h2,
		USC_RX_PAR = 3'h3,
		USC_RX_STOP = 3'h4
	} usc_rx_state_t;
endpackage : usc_pkg

/* File: usc_queue.sv */
// character queue of flip-flops, used for both the transmit and receive buffers
// assumes depth is a power of two; flush wins over a push in the same cycle
`timescale 1ns/1ps
`default_nettype none
module usc_queue
	import usc_pkg::*;
#(
	parameter int W = USC_ENTRY_W,
	parameter int DEPTH = USC_QUEUE_DEPTH,
	parameter int CW = $clog2(DEPTH + 1)
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [W-1:0] push_data,
	input wire logic pop,
	input wire logic flush,
	output logic [W-1:0] head,
	output logic [CW-1:0] count,
	output logic full,
	output logic empty
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
	} usc_queue_t;
	usc_queue_t q_reg;
	usc_queue_t q_next;
	logic do_pop;
	logic do_push;
	assign empty = (q_reg.cnt == '0);
	assign full = (q_reg.cnt == CW'(DEPTH));
	assign count = q_reg.cnt;
	assign head = q_reg.mem[q_reg.rp];
	// a full queue still takes a push when the head leaves in the same cycle
	assign do_pop = pop && !empty;
	assign do_push = push && (!full || do_pop);
	always_comb
	begin
		q_next = q_reg;
		if (flush)
		begin
			q_next.wp = '0;
			q_next.rp = '0;
			q_next.cnt = '0;
		end
		else
		begin
			if (do_push)
			begin
				q_next.mem[q_reg.wp] = push_data;
				q_next.wp = q_reg.wp + PW'(1);
			end
			if (do_pop)
				q_next.rp = q_reg.rp + PW'(1);
			q_next.cnt = q_reg.cnt + CW'(do_push) - CW'(do_pop);
		end
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end
endmodule : usc_queue
`default_nettype wire

/* File: usc_uart.sv */
// serial port core: status/control register, transmit and receive shifters
// assumes bit timing comes as a cycle count per bit; wishbone classic slave
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module usc_uart
	import usc_pkg::*;
#(
	parameter int BIT_CYCLES = USC_BIT_CYCLES,
	parameter int DEPTH = USC_QUEUE_DEPTH
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic rx_line_pin,
	output logic tx_line_pin,
	output logic tx_pin_owned,
	output logic tx_irq,
	output logic rx_irq
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [USC_CNT_W-1:0] BIT_END = USC_CNT_W'(BIT_CYCLES - 1);
	localparam logic [USC_CNT_W-1:0] HALF_BIT = USC_CNT_W'(BIT_CYCLES / 2 - 1);
	localparam logic [USC_CNT_W-1:0] IR_CYC = USC_CNT_W'(BIT_CYCLES / USC_IR_FRACTION);
	typedef struct packed {
		logic [1:0] tx_irq_select;
		logic tx_polarity_invert;
		logic tx_break_request;
		logic tx_enable_bit;
		logic [1:0] rx_irq_select;
		logic address_detect_enable;
		logic overrun_error_flag;
		logic [1:0] data_format_select;
		logic infrared_coding_enable;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [1:0] rx_sync;
		usc_tx_state_t tx_state;
		logic [USC_CNT_W-1:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [USC_DATA_W-1:0] tx_shift;
		logic tx_brk_frame;
		logic tx_par;
		logic tx_line;
		logic tx_owned;
		logic tx_irq;
		usc_rx_state_t rx_state;
		logic [USC_CNT_W-1:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [USC_DATA_W-1:0] rx_shift;
		logic rx_par_bad;
		logic rx_irq;
	} usc_state_t;
	usc_state_t s_reg;
	usc_state_t s_next;
	logic tx_push;
	logic tx_pop;
	logic tx_flush;
	logic [USC_DATA_W-1:0] tx_head;
	logic [CW-1:0] tx_count;
	logic tx_full;
	logic tx_empty;
	logic rx_push;
	logic rx_pop;
	logic rx_flush;
	logic [USC_ENTRY_W-1:0] rx_entry;
	logic [USC_ENTRY_W-1:0] rx_head;
	logic [CW-1:0] rx_count;
	logic [CW-1:0] rx_after;
	logic rx_full;
	logic rx_empty;
	logic take;
	logic nine;
	logic parity_on;
	logic odd;
	logic tx_bit_val;
	logic tx_bit_end;
	logic [3:0] tx_last;
	logic rx_line;
	logic rx_bit_end;
	logic [3:0] rx_last;
	logic rx_accept;
	logic overflow;
	logic overrun_error_flag_clear;
	logic tx_shifter_empty;
	logic [15:0] status_word;
	usc_queue #(.W(USC_DATA_W), .DEPTH(DEPTH)) u_tx_queue (
		.ref_clk(ref_clk),
		.rst(rst),
		.push(tx_push),
		.push_data(wb_dat_i[USC_DATA_W-1:0]),
		.pop(tx_pop),
		.flush(tx_flush),
		.head(tx_head),
		.count(tx_count),
		.full(tx_full),
		.empty(tx_empty)
	);
	usc_queue #(.W(USC_ENTRY_W), .DEPTH(DEPTH)) u_rx_queue (
		.ref_clk(ref_clk),
		.rst(rst),
		.push(rx_push),
		.push_data(rx_entry),
		.pop(rx_pop),
		.flush(rx_flush),
		.head(rx_head),
		.count(rx_count),
		.full(rx_full),
		.empty(rx_empty)
	);
	assign take = wb_cyc_i && wb_stb_i && !s_reg.wb_ack;
	assign nine = (s_reg.data_format_select == USC_FMT_NINE); // [RQ18]
	assign parity_on = (s_reg.data_format_select == USC_FMT_EVEN) || odd;
	assign odd = (s_reg.data_format_select == USC_FMT_ODD);
	assign tx_bit_end = (s_reg.tx_cnt == BIT_END);
	assign tx_last = s_reg.tx_brk_frame ? USC_LAST_BREAK : (nine ? USC_LAST_NINE : USC_LAST_EIGHT);
	assign tx_bit_val = (s_reg.tx_state == USC_TX_START) ? 1'b0 :
		(s_reg.tx_state == USC_TX_DATA) ? s_reg.tx_shift[0] :
		(s_reg.tx_state == USC_TX_PAR) ? s_reg.tx_par : 1'b1;
	assign tx_shifter_empty = (s_reg.tx_state == USC_TX_IDLE) && tx_empty; // [RQ7]
	assign rx_line = s_reg.rx_sync[1];
	assign rx_bit_end = (s_reg.rx_cnt == BIT_END);
	assign rx_last = nine ? USC_LAST_NINE : USC_LAST_EIGHT;
	// address filter only bites in nine-bit format
	assign rx_accept = !(s_reg.address_detect_enable && nine && !s_reg.rx_shift[USC_E_ADDR]); // [RQ11]
	assign rx_entry = {!rx_line, s_reg.rx_par_bad, s_reg.rx_shift};
	assign rx_after = rx_count + CW'(1) - CW'(rx_pop);
	// error flags of an empty queue read zero, not a stale head
	assign status_word = {s_reg.tx_irq_select[1], s_reg.tx_polarity_invert,
		s_reg.tx_irq_select[0], 1'b0, s_reg.tx_break_request, s_reg.tx_enable_bit,
		tx_full, tx_shifter_empty, s_reg.rx_irq_select, s_reg.address_detect_enable,
		s_reg.rx_state == USC_RX_IDLE,
		rx_head[USC_E_PARITY_ERROR_FLAG] && !rx_empty,
		rx_head[USC_E_FRAMING_ERROR_FLAG] && !rx_empty,
		s_reg.overrun_error_flag, !rx_empty}; // [RQ6] [RQ12] [RQ13] [RQ14] [RQ16]
	always_comb
	begin
		s_next = s_reg;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		tx_flush = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_flush = 1'b0;
		overflow = 1'b0;
		overrun_error_flag_clear = 1'b0;
		s_next.wb_ack = 1'b0;
		s_next.tx_irq = 1'b0;
		s_next.rx_irq = 1'b0;
		s_next.rx_sync = {s_reg.rx_sync[0], rx_line_pin};
		s_next.tx_owned = s_reg.tx_enable_bit; // [RQ5]
		// infrared coding sends a short pulse per zero bit and idles at the tx_polarity_invert level
		if (s_reg.infrared_coding_enable)
			s_next.tx_line = (!tx_bit_val && s_reg.tx_cnt < IR_CYC) ^ s_reg.tx_polarity_invert; // [RQ3]
		else
			s_next.tx_line = tx_bit_val ^ s_reg.tx_polarity_invert; // [RQ3]
		if (s_reg.tx_state != USC_TX_IDLE)
			s_next.tx_cnt = tx_bit_end ? '0 : s_reg.tx_cnt + USC_CNT_W'(1);
		if (s_reg.tx_enable_bit)
		begin
			unique case (s_reg.tx_state)
				USC_TX_IDLE:
				begin
					if (!tx_empty)
					begin
						tx_pop = 1'b1;
						s_next.tx_state = USC_TX_START;
						s_next.tx_cnt = '0;
						s_next.tx_bit = '0;
						s_next.tx_brk_frame = s_reg.tx_break_request; // [RQ4]
						s_next.tx_shift = s_reg.tx_break_request ? '0 : tx_head; // [RQ4]
						s_next.tx_par = ^tx_head[USC_LAST_EIGHT:0] ^ odd;
						if (s_reg.tx_irq_select == USC_TXI_XFER)
							s_next.tx_irq = 1'b1; // [RQ1]
						if (s_reg.tx_irq_select == USC_TXI_EMPTY && tx_count == CW'(1))
							s_next.tx_irq = 1'b1; // [RQ1]
					end
				end
				USC_TX_START:
				begin
					if (tx_bit_end)
						s_next.tx_state = USC_TX_DATA;
				end
				USC_TX_DATA:
				begin
					if (tx_bit_end)
					begin
						s_next.tx_shift = s_reg.tx_shift >> 1;
						s_next.tx_bit = s_reg.tx_bit + 4'h1;
						if (s_reg.tx_bit == tx_last)
							s_next.tx_state = (parity_on && !s_reg.tx_brk_frame) ? USC_TX_PAR : USC_TX_STOP;
					end
				end
				USC_TX_PAR:
				begin
					if (tx_bit_end)
						s_next.tx_state = USC_TX_STOP;
				end
				USC_TX_STOP:
				begin
					if (tx_bit_end)
					begin
						s_next.tx_state = USC_TX_IDLE;
						if (s_reg.tx_brk_frame)
							s_next.tx_break_request = 1'b0; // [RQ4]
						if (s_reg.tx_irq_select == USC_TXI_DONE && tx_empty)
							s_next.tx_irq = 1'b1; // [RQ2]
					end
				end
				default:
					s_next.tx_state = USC_TX_IDLE;
			endcase
		end
		if (take)
		begin
			s_next.wb_ack = 1'b1;
			s_next.wb_dat = '0;
			case (wb_adr_i)
				USC_ADR_STATUS:
				begin
					s_next.wb_dat = {16'h0, status_word};
					if (wb_we_i && wb_sel_i[1])
					begin
						s_next.tx_irq_select = {wb_dat_i[USC_B_TXISEL1], wb_dat_i[USC_B_TXISEL0]};
						s_next.tx_polarity_invert = wb_dat_i[USC_B_TX_POLARITY_INVERT];
						s_next.tx_break_request = wb_dat_i[USC_B_TXBRK];
						s_next.tx_enable_bit = wb_dat_i[USC_B_TXEN];
						if (s_reg.tx_enable_bit && !wb_dat_i[USC_B_TXEN])
						begin
							tx_flush = 1'b1; // [RQ5]
							s_next.tx_state = USC_TX_IDLE; // [RQ5]
							s_next.tx_cnt = '0;
						end
						if (!s_reg.tx_enable_bit && wb_dat_i[USC_B_TXEN])
							s_next.tx_irq = 1'b1;
					end
					if (wb_we_i && wb_sel_i[0])
					begin
						s_next.rx_irq_select = {wb_dat_i[USC_B_RXISEL1], wb_dat_i[USC_B_RXISEL0]};
						s_next.address_detect_enable = wb_dat_i[USC_B_ADDRESS_DETECT_ENABLE];
						overrun_error_flag_clear = s_reg.overrun_error_flag && !wb_dat_i[USC_B_OVERRUN_ERROR_FLAG]; // [RQ20]
					end
				end
				USC_ADR_TXDATA:
					tx_push = wb_we_i && wb_sel_i[0];
				USC_ADR_RXDATA:
				begin
					s_next.wb_dat = {23'h0, rx_head[USC_DATA_W-1:0]};
					rx_pop = !wb_we_i; // [RQ17]
				end
				USC_ADR_CONFIG:
				begin
					s_next.wb_dat = {29'h0, s_reg.infrared_coding_enable, s_reg.data_format_select};
					if (wb_we_i && wb_sel_i[0])
					begin
						s_next.data_format_select = {wb_dat_i[USC_B_FMT1], wb_dat_i[USC_B_FMT0]};
						s_next.infrared_coding_enable = wb_dat_i[USC_B_INFRARED_CODING_ENABLE];
					end
				end
				default:
					s_next.wb_dat = '0;
			endcase
		end
		if (s_reg.rx_state != USC_RX_IDLE)
			s_next.rx_cnt = s_reg.rx_cnt + USC_CNT_W'(1);
		unique case (s_reg.rx_state)
			USC_RX_IDLE:
			begin
				if (!rx_line)
				begin
					s_next.rx_state = USC_RX_START; // [RQ12]
					s_next.rx_cnt = '0;
				end
			end
			USC_RX_START:
			begin
				// re-check at mid bit so a glitch is not taken for a start
				if (s_reg.rx_cnt == HALF_BIT)
				begin
					s_next.rx_state = rx_line ? USC_RX_IDLE : USC_RX_DATA;
					s_next.rx_cnt = '0;
					s_next.rx_bit = '0;
					s_next.rx_shift = '0;
					s_next.rx_par_bad = 1'b0;
				end
			end
			USC_RX_DATA:
			begin
				if (rx_bit_end)
				begin
					s_next.rx_cnt = '0;
					s_next.rx_shift[s_reg.rx_bit] = rx_line;
					s_next.rx_bit = s_reg.rx_bit + 4'h1;
					if (s_reg.rx_bit == rx_last)
						s_next.rx_state = parity_on ? USC_RX_PAR : USC_RX_STOP;
				end
			end
			USC_RX_PAR:
			begin
				if (rx_bit_end)
				begin
					s_next.rx_cnt = '0;
					s_next.rx_par_bad = rx_line != (^s_reg.rx_shift[USC_LAST_EIGHT:0] ^ odd); // [RQ13]
					s_next.rx_state = USC_RX_STOP;
				end
			end
			USC_RX_STOP:
			begin
				if (rx_bit_end)
				begin
					s_next.rx_state = USC_RX_IDLE;
					if (rx_accept && rx_full && !rx_pop)
						overflow = 1'b1; // [RQ15]
					else if (rx_accept)
					begin
						rx_push = 1'b1; // [RQ14]
						if (!s_reg.rx_irq_select[1])
							s_next.rx_irq = 1'b1; // [RQ10]
						if (s_reg.rx_irq_select == USC_RXI_FULL && rx_after == CW'(USC_RX_FULL_LEVEL))
							s_next.rx_irq = 1'b1; // [RQ8]
						if (s_reg.rx_irq_select == USC_RXI_3Q && rx_after == CW'(USC_RX_3Q_LEVEL))
							s_next.rx_irq = 1'b1; // [RQ9]
					end
				end
			end
			default:
				s_next.rx_state = USC_RX_IDLE;
		endcase
		// a fresh overflow beats a software clear in the same cycle
		if (overflow)
			s_next.overrun_error_flag = 1'b1; // [RQ15]
		else if (overrun_error_flag_clear)
		begin
			s_next.overrun_error_flag = 1'b0;
			rx_flush = 1'b1; // [RQ15]
			s_next.rx_state = USC_RX_IDLE;
			s_next.rx_cnt = '0;
		end
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg <= '0; // [RQ21]
			s_reg.rx_sync <= 2'h3;
			s_reg.tx_line <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
	assign wb_ack_o = s_reg.wb_ack;
	assign wb_dat_o = s_reg.wb_dat;
	assign tx_line_pin = s_reg.tx_line;
	assign tx_pin_owned = s_reg.tx_owned;
	assign tx_irq = s_reg.tx_irq;
	assign rx_irq = s_reg.rx_irq;
	default clocking usc_cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_status_read;
		s_take ##0 (!wb_we_i && wb_adr_i == USC_ADR_STATUS);
	endsequence
	sequence s_tx_disable;
		s_take ##0 (wb_we_i && wb_adr_i == USC_ADR_STATUS && wb_sel_i[1]
			&& !wb_dat_i[USC_B_TXEN] && s_reg.tx_enable_bit);
	endsequence
	sequence s_tx_last_stop;
		s_reg.tx_enable_bit && s_reg.tx_state == USC_TX_STOP && tx_bit_end;
	endsequence
	a_tx_xfer_irq: assert property (s_reg.tx_enable_bit && s_reg.tx_state == USC_TX_IDLE
		&& !tx_empty && s_reg.tx_irq_select == USC_TXI_XFER |=> tx_irq) // [RQ1]
		else $error("transfer into shifter gave no tx irq");
	a_tx_done_irq: assert property (s_tx_last_stop ##0 (tx_empty
		&& s_reg.tx_irq_select == USC_TXI_DONE) |=> tx_irq) // [RQ2]
		else $error("end of transmission gave no tx irq");
	a_tx_idle_level: assert property (s_reg.tx_state == USC_TX_IDLE
		&& !s_reg.infrared_coding_enable |=> tx_line_pin == !$past(s_reg.tx_polarity_invert)) // [RQ3]
		else $error("tx idle level does not follow polarity");
	a_break_zeros: assert property (s_reg.tx_state == USC_TX_DATA && s_reg.tx_brk_frame
		&& !s_reg.infrared_coding_enable |=> tx_line_pin == $past(s_reg.tx_polarity_invert)) // [RQ4]
		else $error("break frame bit not zero");
	a_break_selfclear: assert property (s_tx_last_stop ##0 (s_reg.tx_brk_frame
		&& !(wb_cyc_i && wb_stb_i)) |=> !s_reg.tx_break_request) // [RQ4]
		else $error("break request not cleared after break");
	a_tx_disable: assert property (s_tx_disable |=> (s_reg.tx_state == USC_TX_IDLE
		&& tx_empty) ##1 !tx_pin_owned) // [RQ5]
		else $error("tx disable did not abort and release pin");
	a_full_flag: assert property (s_status_read |=> wb_dat_o[USC_B_TXBF] == $past(tx_full)) // [RQ6]
		else $error("tx full flag wrong");
	a_shifter_flag: assert property (s_status_read |=> wb_dat_o[USC_B_TX_SHIFTER_EMPTY]
		== $past(tx_empty && s_reg.tx_state == USC_TX_IDLE)) // [RQ7]
		else $error("shifter empty flag wrong");
	a_rx_full_irq: assert property (rx_push && s_reg.rx_irq_select == USC_RXI_FULL
		&& rx_after == CW'(USC_RX_FULL_LEVEL) |=> rx_irq) // [RQ8]
		else $error("rx full irq missing");
	a_rx_any_irq: assert property (rx_push && !s_reg.rx_irq_select[1] |=> rx_irq) // [RQ10]
		else $error("rx irq per character missing");
	a_rx_ready_flag: assert property (s_status_read |=> wb_dat_o[USC_B_RX_DATA_AVAILABLE]
		== $past(!rx_empty)) // [RQ16]
		else $error("data available flag wrong");
	a_overrun_hold: assert property (s_reg.overrun_error_flag && !overrun_error_flag_clear
		|=> s_reg.overrun_error_flag) // [RQ20]
		else $error("overrun flag dropped without clear");
	a_overrun_flush: assert property (overrun_error_flag_clear && !overflow |=> rx_empty
		&& !s_reg.overrun_error_flag && s_reg.rx_state == USC_RX_IDLE) // [RQ15]
		else $error("overrun clear did not flush receiver");
endmodule : usc_uart
`default_nettype wire

/* File: usc_remote.sv */
// remote serial transceiver: drives the receive line, decodes the transmit line
// assumes bc clock cycles per bit and idle-high lines; nbits set by the bench
`timescale 1ns/1ps
`default_nettype none
module usc_remote #(
	parameter int BC = 8
)
(
	input wire logic ref_clk,
	input wire logic tx_line_pin,
	output logic rx_line_pin
);
	int nbits = 8;
	logic [12:0] frames[$];
	logic [12:0] f;
	initial rx_line_pin = 1'b1;
	task automatic put(input logic b);
		@(posedge ref_clk);
		rx_line_pin <= b;
		repeat (BC - 1) @(posedge ref_clk);
	endtask : put
	// par: 0 none, 1 even, 2 odd; bp and bs corrupt parity and stop on purpose
	task automatic send(input logic [8:0] d, input int nb, input int par, input bit bp,
		input bit bs);
		logic p;
		p = ^d[7:0] ^ (par == 2) ^ bp;
		put(1'b0);
		for (int i = 0; i < nb; i++)
			put(d[i]);
		if (par != 0)
			put(p);
		put(~bs);
		// one idle bit so a bad stop still leaves a clean start edge
		put(1'b1);
	endtask : send
	always
	begin
		@(negedge tx_line_pin);
		repeat (BC / 2) @(posedge ref_clk);
		f = '0;
		for (int i = 0; i <= nbits; i++)
		begin
			repeat (BC) @(posedge ref_clk);
			f[i] = tx_line_pin;
		end
		frames.push_back(f);
	end
endmodule : usc_remote
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the serial status and control block
// assumes the remote model on both serial lines; bit time shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
	import usc_pkg::*;
	localparam int BC = 8;
	localparam logic [3:0] S = USC_ADR_STATUS;
	logic ref_clk, rst, cyc, stb, we, ack, rxp, txp, own, tx_irq, rx_irq;
	logic [3:0] adr, sel;
	logic [31:0] dat, dato;
	logic [15:0] v;
	logic [8:0] d;
	logic [8:0] dq[3];
	int n_mismatch = 0, check_count = 0, ntx = 0, nrx = 0;
	int te[4] = '{3, 1, 2, 0};
	int e3[4] = '{3, 3, 1, 0};
	int e4[4] = '{4, 4, 1, 1};
	usc_uart #(.BIT_CYCLES(BC), .DEPTH(4)) DUT (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_ack_o(ack), .wb_dat_o(dato), .rx_line_pin(rxp), .tx_line_pin(txp),
		.tx_pin_owned(own), .tx_irq(tx_irq), .rx_irq(rx_irq));
	usc_remote #(.BC(BC)) REM (.ref_clk(ref_clk), .tx_line_pin(txp), .rx_line_pin(rxp));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// count on the falling edge so the pulse is read while it stands, clear of the launch edge
	always @(negedge ref_clk)
	begin
		if (tx_irq === 1'b1)
			ntx++;
		if (rx_irq === 1'b1)
			nrx++;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] x);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0, x};
		do
			@(negedge ref_clk);
		while (ack !== 1'b1 && ++t < 50);
		if (ack !== 1'b1)
			n_mismatch++;
		v = dato[15:0];
		// hold the request through the rising edge at which ack is high
		@(posedge ref_clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic idle_wait;
		for (int t = 0; t < 300; t++)
		begin
			bus(1'b0, S, 16'h0);
			if (v[USC_B_TX_SHIFTER_EMPTY] === 1'b1)
				break;
		end
	endtask : idle_wait
	task automatic frame_wait(input int n);
		for (int t = 0; t < 3000 && REM.frames.size() < n; t++)
			@(posedge ref_clk);
	endtask : frame_wait
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial
	begin
		// watchdog sized well above the few thousand cycles the tests need
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		{rst, cyc, stb, we, adr, sel, dat} = {1'b1, 43'h0};
		sel = 4'h3;
		void'($urandom(32'hb93b07b2));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		bus(1'b0, S, 16'h0);
		chk("reset status", v, 16'h0110);
		bus(1'b1, S, 16'h131f);
		bus(1'b0, S, 16'h0);
		chk("read-only bits", v, 16'h0110);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, S, {i[1], 1'b0, i[0], 13'h0400});
			chk("pin owned", {15'h0, own}, 16'h1);
			repeat (3) @(posedge ref_clk);
			ntx = 0;
			for (int k = 0; k < 3; k++)
			begin
				dq[k] = 9'($urandom) & 9'h0ff;
				bus(1'b1, USC_ADR_TXDATA, {7'h0, dq[k]});
			end
			bus(1'b0, S, 16'h0);
			chk("shifter busy", {15'h0, v[USC_B_TX_SHIFTER_EMPTY]}, 16'h0);
			idle_wait();
			chk("shifter empty", {15'h0, v[USC_B_TX_SHIFTER_EMPTY]}, 16'h1);
			repeat (2 * BC) @(posedge ref_clk);
			chk("tx irq count", 16'(ntx), 16'(te[i]));
			for (int k = 0; k < 3; k++)
				chk("tx frame", {3'h0, REM.frames.pop_front()}, {7'h0, dq[k] | 9'h100});
		end
		$display("test tx irq done");
		// dummy character starts the break, sync byte follows
		bus(1'b1, S, 16'h0c00);
		REM.nbits = 12;
		bus(1'b1, USC_ADR_TXDATA, 16'h0);
		bus(1'b1, USC_ADR_TXDATA, 16'h0055);
		frame_wait(1);
		REM.nbits = 8;
		chk("break frame", {3'h0, REM.frames.pop_front()}, 16'h1000);
		idle_wait();
		chk("break cleared", {15'h0, v[USC_B_TXBRK]}, 16'h0);
		frame_wait(1);
		chk("sync frame", {3'h0, REM.frames.pop_front()}, 16'h0155);
		for (int k = 0; k < 6; k++)
			bus(1'b1, USC_ADR_TXDATA, 16'(k));
		bus(1'b0, S, 16'h0);
		chk("tx full", {15'h0, v[USC_B_TXBF]}, 16'h1);
		bus(1'b1, S, 16'h0);
		bus(1'b0, S, 16'h0);
		chk("abort flush", v, 16'h0110);
		chk("pin released", {15'h0, own}, 16'h0);
		$display("test break and abort done");
		d = 9'($urandom) & 9'h0ff;
		fork
			REM.send(d, 8, 0, 1'b0, 1'b0);
			begin
				repeat (3 * BC) @(posedge ref_clk);
				bus(1'b0, S, 16'h0);
			end
		join
		chk("rx busy", {15'h0, v[USC_B_RX_IDLE_FLAG]}, 16'h0);
		repeat (2) @(posedge ref_clk);
		bus(1'b0, S, 16'h0);
		chk("rx avail", v, 16'h0111);
		bus(1'b0, USC_ADR_RXDATA, 16'h0);
		chk("rx data", v, {7'h0, d});
		bus(1'b0, S, 16'h0);
		chk("rx empty", v, 16'h0110);
		bus(1'b1, USC_ADR_CONFIG, 16'h0001);
		for (int k = 0; k < 3; k++)
		begin
			dq[k] = 9'($urandom) & 9'h0ff;
			REM.send(dq[k], 8, 1, k == 0, k == 1);
		end
		for (int k = 0; k < 3; k++)
		begin
			bus(1'b0, S, 16'h0);
			chk("head errors", {14'h0, v[3:2]}, 16'(4'h8 >> (k + 2)));
			bus(1'b0, USC_ADR_RXDATA, 16'h0);
			chk("rx data", v, {7'h0, dq[k]});
		end
		$display("test rx errors done");
		bus(1'b1, USC_ADR_CONFIG, 16'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, S, {8'h0, i[1:0], 6'h0});
			nrx = 0;
			for (int k = 0; k < 4; k++)
			begin
				REM.send(9'($urandom) & 9'h0ff, 8, 0, 1'b0, 1'b0);
				if (k == 2)
					chk("rx irq at 3", 16'(nrx), 16'(e3[i]));
			end
			repeat (4) @(posedge ref_clk);
			chk("rx irq at 4", 16'(nrx), 16'(e4[i]));
			for (int k = 0; k < 4; k++)
				bus(1'b0, USC_ADR_RXDATA, 16'h0);
		end
		bus(1'b1, S, 16'h0);
		for (int k = 0; k < 5; k++)
			REM.send(9'(k), 8, 0, 1'b0, 1'b0);
		bus(1'b0, S, 16'h0);
		chk("overrun set", {14'h0, v[1:0]}, 16'h3);
		bus(1'b1, S, 16'h0002);
		bus(1'b0, S, 16'h0);
		chk("overrun kept", {15'h0, v[USC_B_OVERRUN_ERROR_FLAG]}, 16'h1);
		bus(1'b1, S, 16'h0);
		bus(1'b0, S, 16'h0);
		chk("overrun flush", v, 16'h0110);
		bus(1'b1, USC_ADR_CONFIG, 16'h0003);
		bus(1'b1, S, 16'h0020);
		d = 9'($urandom) | 9'h100;
		REM.send(d & 9'h0ff, 9, 0, 1'b0, 1'b0);
		REM.send(d, 9, 0, 1'b0, 1'b0);
		bus(1'b0, USC_ADR_RXDATA, 16'h0);
		chk("address char", v, {7'h0, d});
		bus(1'b0, S, 16'h0);
		chk("data char dropped", {15'h0, v[USC_B_RX_DATA_AVAILABLE]}, 16'h0);
		bus(1'b1, USC_ADR_CONFIG, 16'h0);
		REM.send(9'h011, 8, 0, 1'b0, 1'b0);
		bus(1'b0, S, 16'h0);
		chk("detect inert", {15'h0, v[USC_B_RX_DATA_AVAILABLE]}, 16'h1);
		bus(1'b0, USC_ADR_RXDATA, 16'h0);
		$display("test rx modes done");
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, USC_ADR_CONFIG, {13'h0, i[1], 2'h0});
			bus(1'b1, S, {1'b0, i[0], 14'h0400});
			repeat (4) @(posedge ref_clk);
			chk("tx idle level", {15'h0, txp}, {15'h0, ~(i[0] ^ i[1])});
		end
		$display("test polarity done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
